// *** src/console_switch_pkg.sv ***
package console_switch_pkg;

    // ------------------------------------------------------------
    // Switch indices
    // ------------------------------------------------------------
    localparam int unsigned NUM_KEYS = 5;
    localparam int unsigned KEY_SET_ADDRESS = 0;
    localparam int unsigned KEY_INSPECT = 1;
    localparam int unsigned KEY_RESUME = 2;
    localparam int unsigned KEY_STORE = 3;
    localparam int unsigned KEY_START = 4;

    // ------------------------------------------------------------
    // Reset values and synchroniser depth
    // ------------------------------------------------------------
    localparam logic LATCH_SET_VALUE = 1'h1;
    localparam logic [4:0] KEYS_IDLE = 5'h1F;
    localparam int unsigned SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Power restore hold time seen from the power logic
    // ------------------------------------------------------------
    localparam int unsigned POWER_HOLD_MS = 70;
    localparam int unsigned CLOCK_HZ = 20000000;
    localparam longint unsigned POWER_HOLD_CYCLES =
        (longint'(POWER_HOLD_MS) * longint'(CLOCK_HZ)) / 64'd1000;

    // ------------------------------------------------------------
    // Register port, offsets of plain status and control words
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_SWITCHES = 4'h4;
    localparam logic [3:0] REG_RESTORE = 4'h8;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

endpackage

// *** src/switch_holding_latch.sv ***
`timescale 1ns/1ps
`default_nettype none

// Clocked form of a cross-coupled set/reset latch with active-low inputs.
module switch_holding_latch (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic set_n_in,
    input wire logic reset_n_in,
    output logic q_out
);

    logic q_q;
    logic q_d;

    // Set wins when both inputs are low, as the extra set path must dominate.
    assign q_d = !set_n_in ? 1'b1 : (!reset_n_in ? 1'b0 : q_q);
    assign q_out = q_q;

    // Holding flip-flop; with both inputs high it keeps its state.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            q_q <= console_switch_pkg::LATCH_SET_VALUE;
        end else begin
            q_q <= q_d;
        end
    end

endmodule

`default_nettype wire

// *** src/console_switch_conditioning.sv ***
// Functional notes
// - Six switches: run/stop toggle and five momentary keys.
// - Store key acts when lifted; other keys act when pressed.
// - Each switch output passes a holding set/reset latch against bounce.
// - Keys assert low when active; run/stop asserts low at stop.
// - Common input high only if power good and lockout both high.
// - Lockout line high in lockout key position, low in on position.
// - Common low: rest sets latch high, active resets latch low.
// - Run/stop high at run lets program run; low halts processor.
// - Under lockout moving any switch leaves its latch set.
// - After power loss without lockout switches act on their position.
// - Stop position during restore resets run/stop latch, asserting stop.
// - Power good rising under lockout sets run/stop latch, clearing stop.
// - Extra run/stop set path has no effect with lockout off.
`timescale 1ns/1ps
`default_nettype none

module console_switch_conditioning (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic run_position_in,
    input wire logic set_address_key_down_in,
    input wire logic inspect_key_down_in,
    input wire logic resume_key_down_in,
    input wire logic store_key_up_in,
    input wire logic start_key_down_in,
    input wire logic power_good_n_in,
    input wire logic lockout_key_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    output logic set_address_key_out_n,
    output logic inspect_key_out_n,
    output logic resume_key_out_n,
    output logic store_key_out_n,
    output logic start_key_out_n,
    output logic run_stop_out_n,
    output logic common_input_out
);

    // ------------------------------------------------------------
    // Common input network
    // ------------------------------------------------------------

    logic lockout_line;
    logic common_input;
    logic extra_set_n;
    logic power_good_prev_q;
    logic power_rise;

    // lockout line level
    // The line is grounded in the on position, pulled high in lockout.
    assign lockout_line = lockout_key_in;
    assign common_input = power_good_n_in && lockout_line;
    // inverted common input
    // With lockout off the common input is always low, so this set path stays
    // inactive and the toggle alone decides; under lockout it forces the latch
    // set, so a restore that reset it cannot leave the processor halted.
    assign extra_set_n = !common_input;
    assign power_rise = power_good_n_in && !power_good_prev_q;

    // ------------------------------------------------------------
    // Switch contacts to latch inputs
    // ------------------------------------------------------------

    logic [4:0] key_active;
    logic [4:0] key_latch_q;
    logic run_latch_q;
    logic run_set_n;
    logic run_reset_n;

    // activation sense
    // The store key is active up; all others are active down.
    assign key_active[console_switch_pkg::KEY_SET_ADDRESS] = set_address_key_down_in;
    assign key_active[console_switch_pkg::KEY_INSPECT] = inspect_key_down_in;
    assign key_active[console_switch_pkg::KEY_RESUME] = resume_key_down_in;
    assign key_active[console_switch_pkg::KEY_STORE] = store_key_up_in;
    assign key_active[console_switch_pkg::KEY_START] = start_key_down_in;

    // common high blocks change
    // The contact routes the common input to the set or reset terminal; the
    // other terminal floats high.  A high common input thus cannot move a latch.
    genvar gi;
    generate
        for (gi = 0; gi < console_switch_pkg::NUM_KEYS; gi++) begin : g_key
            switch_holding_latch u_latch (
                .clock_in(clock_in),
                .nrst_in(nrst_in),
                .set_n_in(key_active[gi] || common_input),
                .reset_n_in(!key_active[gi] || common_input),
                .q_out(key_latch_q[gi])
            );
        end
    endgenerate

    // extra set path masked
    // A low common input lets the contacts drive; the inverted common path
    // only adds a set when lockout and power good are both high.
    assign run_reset_n = run_position_in || common_input;
    assign run_set_n = (!run_position_in || common_input) && extra_set_n;

    switch_holding_latch u_run_latch (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .set_n_in(run_set_n),
        .reset_n_in(run_reset_n),
        .q_out(run_latch_q)
    );

    // ------------------------------------------------------------
    // Two-stage synchroniser toward the processor
    // ------------------------------------------------------------

    logic [5:0] sync1_q;
    logic [5:0] sync2_q;

    // two flip-flop stages
    // The first stage feeds only the second one.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sync1_q <= {console_switch_pkg::LATCH_SET_VALUE, console_switch_pkg::KEYS_IDLE};
            sync2_q <= {console_switch_pkg::LATCH_SET_VALUE, console_switch_pkg::KEYS_IDLE};
        end else begin
            sync1_q <= {run_latch_q, key_latch_q};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            set_address_key_out_n <= console_switch_pkg::LATCH_SET_VALUE;
            inspect_key_out_n <= console_switch_pkg::LATCH_SET_VALUE;
            resume_key_out_n <= console_switch_pkg::LATCH_SET_VALUE;
            store_key_out_n <= console_switch_pkg::LATCH_SET_VALUE;
            start_key_out_n <= console_switch_pkg::LATCH_SET_VALUE;
            run_stop_out_n <= console_switch_pkg::LATCH_SET_VALUE;
            common_input_out <= 1'b0;
        end else begin
            set_address_key_out_n <= sync2_q[console_switch_pkg::KEY_SET_ADDRESS];
            inspect_key_out_n <= sync2_q[console_switch_pkg::KEY_INSPECT];
            resume_key_out_n <= sync2_q[console_switch_pkg::KEY_RESUME];
            store_key_out_n <= sync2_q[console_switch_pkg::KEY_STORE];
            start_key_out_n <= sync2_q[console_switch_pkg::KEY_START];
            run_stop_out_n <= sync2_q[console_switch_pkg::NUM_KEYS];
            common_input_out <= common_input;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------

    logic restore_seen_q;
    logic [31:0] read_word;

    // Power good edge tracking; the sticky flag records a restore under lockout.
    // A new rise in the cycle of a clear write wins over the clear.
    // The edge history resets to the idle high level, so no false rise follows reset.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            power_good_prev_q <= 1'b1;
            restore_seen_q <= 1'b0;
        end else begin
            power_good_prev_q <= power_good_n_in;
            if (power_rise && lockout_line) begin
                restore_seen_q <= 1'b1;
            end else if (reg_write_in && reg_addr_in == console_switch_pkg::REG_RESTORE
                         && reg_wdata_in[0]) begin
                restore_seen_q <= 1'b0;
            end
        end
    end

    // Read decode; unmapped offsets read as zero.
    assign read_word =
        (reg_addr_in == console_switch_pkg::REG_STATUS) ?
            {29'h0, common_input, lockout_line, power_good_n_in} :
        (reg_addr_in == console_switch_pkg::REG_SWITCHES) ?
            {26'h0, run_latch_q, key_latch_q} :
        (reg_addr_in == console_switch_pkg::REG_RESTORE) ?
            {31'h0, restore_seen_q} :
            console_switch_pkg::READ_ZERO;

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= console_switch_pkg::READ_ZERO;
        end else begin
            reg_rdata_out <= reg_read_in ? read_word : console_switch_pkg::READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    // Latch checks look one edge ahead; switch output checks look three edges back.
    a_common_gate: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $past(nrst_in) |->
            common_input_out == ($past(power_good_n_in) && $past(lockout_key_in)))
        else $error("common output does not follow power good and lockout");

    a_lock_keeps_set: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (common_input && key_latch_q[0]) |=> key_latch_q[0])
        else $error("key latch changed under lockout");

    a_key_reset: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && key_active[1]) |=> !key_latch_q[1])
        else $error("active key did not reset latch");

    a_key_rest_set: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && !key_active[3]) |=> key_latch_q[3])
        else $error("resting store key did not set latch");

    a_stop_restore: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!power_good_n_in && !run_position_in) |=> !run_latch_q)
        else $error("stop position did not reset run latch");

    a_resume_lock: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (power_rise && lockout_key_in) |=> run_latch_q)
        else $error("run latch not set on power return under lockout");

    a_sync_delay: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $past(nrst_in, 3) |-> run_stop_out_n == $past(run_latch_q, 3))
        else $error("run output not three cycles behind latch");

    a_key_out_delay: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $past(nrst_in, 3) |-> store_key_out_n == $past(key_latch_q[3], 3))
        else $error("store output not three cycles behind latch");

    a_addr_out_delay: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        $past(nrst_in, 3) |-> set_address_key_out_n ==
            $past(key_latch_q[console_switch_pkg::KEY_SET_ADDRESS], 3))
        else $error("set address output not three cycles behind latch");

    a_lock_run_set: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        common_input |=> run_latch_q)
        else $error("run latch not held set under lockout");

    a_run_sets: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && run_position_in) |=> run_latch_q)
        else $error("run position did not set run latch");

    a_open_stop: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!lockout_key_in && !run_position_in) |=> !run_latch_q)
        else $error("extra set path overrode stop with lockout off");

    a_store_reset: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && store_key_up_in) |=> !key_latch_q[console_switch_pkg::KEY_STORE])
        else $error("lifted store key did not reset latch");

    a_start_reset: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && start_key_down_in) |=> !key_latch_q[console_switch_pkg::KEY_START])
        else $error("pressed start key did not reset latch");

    a_addr_reset: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && set_address_key_down_in) |=>
            !key_latch_q[console_switch_pkg::KEY_SET_ADDRESS])
        else $error("pressed set address key did not reset latch");

    a_resume_reset: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (!common_input && resume_key_down_in) |=> !key_latch_q[console_switch_pkg::KEY_RESUME])
        else $error("pressed resume key did not reset latch");

    a_lock_hold_all: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (common_input && key_latch_q == console_switch_pkg::KEYS_IDLE) |=>
            key_latch_q == console_switch_pkg::KEYS_IDLE)
        else $error("key latches left set state under lockout");

    a_restore_flag: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        (power_rise && lockout_line) |=> restore_seen_q)
        else $error("restore flag not set on power return under lockout");

    a_read_idle: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        ($past(nrst_in) && !$past(reg_read_in)) |-> reg_rdata_out == console_switch_pkg::READ_ZERO)
        else $error("read data not zero outside the read answer cycle");

endmodule

`default_nettype wire

// *** tb/power_restore_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Processor power logic and halt sensing
// ------------------------------------------------------------
module power_restore_model #(
    parameter int HOLD_CYCLES = 20
) (
    input wire logic clock_in,
    input wire logic restore_in,
    input wire logic run_stop_n_in,
    output logic power_good_n_out,
    output logic halted_out
);
    int count_q = 0;

    // Hold power good low.
    // A new request restarts the count, so the line never rises early.
    always_ff @(posedge clock_in) begin
        if (restore_in) begin
            count_q <= HOLD_CYCLES;
        end else if (count_q > 0) begin
            count_q <= count_q - 1;
        end
    end
    assign power_good_n_out = (count_q == 0);

    // Halt on stop.
    // The processor only halts on the latched output, never on the toggle itself.
    always_ff @(posedge clock_in) begin
        halted_out <= !run_stop_n_in;
    end
endmodule

`default_nettype wire

// *** tb/test_console_switch_conditioning.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_console_switch_conditioning;
    localparam int HOLD = 20;
    logic clock_in = 1'h0;
    logic nrst_in = 1'h0;
    logic run_position = 1'h1;
    logic [4:0] keys = 5'h00;
    logic lockout = 1'h0;
    logic restore = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [31:0] rdata;
    logic [5:0] outs_n;
    logic common;
    logic power_good_n;
    logic halted;
    int miscompares = 0;
    int samples_checked = 0;

    always #25 clock_in = ~clock_in;

    console_switch_conditioning u_dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .run_position_in(run_position), .set_address_key_down_in(keys[0]),
        .inspect_key_down_in(keys[1]), .resume_key_down_in(keys[2]),
        .store_key_up_in(keys[3]), .start_key_down_in(keys[4]),
        .power_good_n_in(power_good_n), .lockout_key_in(lockout), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
        .set_address_key_out_n(outs_n[0]), .inspect_key_out_n(outs_n[1]),
        .resume_key_out_n(outs_n[2]), .store_key_out_n(outs_n[3]),
        .start_key_out_n(outs_n[4]), .run_stop_out_n(outs_n[5]), .common_input_out(common));

    power_restore_model #(.HOLD_CYCLES(HOLD)) u_power (.clock_in(clock_in),
        .restore_in(restore), .run_stop_n_in(outs_n[5]),
        .power_good_n_out(power_good_n), .halted_out(halted));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    // Every result is widened to one word, so a single compare serves all.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Outputs lag the switches by four edges; six leaves margin.
    task automatic settle();
        repeat (6) @(posedge clock_in);
        #1;
    endtask

    task automatic apply(input logic run, input logic [4:0] k, input logic lk);
        @(posedge clock_in);
        run_position <= run;
        keys <= k;
        lockout <= lk;
        settle();
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string msg);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'h1;
        @(posedge clock_in);
        rd <= 1'h0;
        #1;
        chk(rdata, exp, msg);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clock_in);
        wr <= 1'h0;
    endtask

    task automatic power_cycle();
        @(posedge clock_in);
        restore <= 1'h1;
        @(posedge clock_in);
        restore <= 1'h0;
        settle();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_keys();
        for (int i = 0; i < 5; i++) begin
            apply(1'h1, 5'h01 << i, 1'h0);
            chk({26'h0, outs_n}, {26'h0, 6'h3F & ~(6'h01 << i)}, "key");
        end
        apply(1'h1, 5'h00, 1'h0);
        chk({26'h0, outs_n}, 32'h0000003F, "keys at rest");
    endtask

    task automatic t_latency();
        @(posedge clock_in);
        keys <= 5'h02;
        repeat (3) @(posedge clock_in);
        #1;
        chk({31'h0, outs_n[1]}, 32'h00000001, "inspect before sync");
        @(posedge clock_in);
        #1;
        chk({31'h0, outs_n[1]}, 32'h00000000, "inspect after sync");
        apply(1'h1, 5'h00, 1'h0);
    endtask

    task automatic t_run_stop();
        apply(1'h0, 5'h00, 1'h0);
        chk({26'h0, outs_n}, 32'h0000001F, "stop output");
        chk({31'h0, halted}, 32'h00000001, "halt at stop");
        chk({31'h0, common}, 32'h00000000, "common unlocked");
        apply(1'h1, 5'h00, 1'h0);
        chk({31'h0, halted}, 32'h00000000, "run at enable");
    endtask

    task automatic t_lockout();
        apply(1'h1, 5'h00, 1'h1);
        chk({31'h0, common}, 32'h00000001, "common locked");
        apply(1'h0, 5'h1F, 1'h1);
        chk({26'h0, outs_n}, 32'h0000003F, "locked switches");
        reg_read(4'h0, 32'h00000007, "status word");
    endtask

    task automatic t_restore_locked();
        apply(1'h0, 5'h00, 1'h1);
        power_cycle();
        chk({26'h0, outs_n}, 32'h0000001F, "stop in restore");
        chk({31'h0, common}, 32'h00000000, "common forced");
        repeat (HOLD) @(posedge clock_in);
        settle();
        chk({26'h0, outs_n}, 32'h0000003F, "stop cleared");
        reg_read(4'h8, 32'h00000001, "restore flag");
        reg_write(4'h8, 32'h00000001);
        reg_read(4'h8, 32'h00000000, "flag cleared");
        reg_read(4'hC, 32'h00000000, "unmapped");
    endtask

    task automatic t_restore_open();
        apply(1'h0, 5'h04, 1'h0);
        power_cycle();
        repeat (HOLD) @(posedge clock_in);
        settle();
        chk({26'h0, outs_n}, 32'h0000001B, "after restore");
        reg_read(4'h4, 32'h0000001B, "latch word");
        reg_read(4'h8, 32'h00000000, "no flag");
    endtask

    // ------------------------------------------------------------
    // Verdict and run control
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The tests take well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'h1;
        t_keys();
        t_latency();
        t_run_stop();
        t_lockout();
        t_restore_locked();
        t_restore_open();
        final_report();
    end
endmodule

`default_nettype wire
